/* File: design/dra_pkg.sv */
// constants, types and register map of the refresh and address controller
package dra_pkg;

   // ==========================================================
   // widths
   localparam int ADDR_W = 10;
   localparam int CNT_W = 9;
   localparam int BANKS = 4;
   localparam int BUS_AW = 4;
   localparam int BUS_DW = 32;

   // ==========================================================
   // counter limits
   localparam logic [CNT_W-1:0] CNT_ZERO = 9'h000;
   localparam logic [CNT_W-1:0] CNT_ONE = 9'h001;
   localparam logic [CNT_W-1:0] CNT_LAST = 9'h1FF;

   // ==========================================================
   // register map, byte addresses
   localparam logic [BUS_AW-1:0] ADDR_CTRL = 4'h0;
   localparam logic [BUS_AW-1:0] ADDR_STATUS = 4'h4;
   localparam logic [BUS_AW-1:0] ADDR_DONE = 4'h8;

   // control fields
   localparam int CTRL_PAIRED_BIT = 0;
   localparam int CTRL_CLEAR_BIT = 1;
   localparam logic CTRL_PAIRED_RST = 1'b0;

   // status fields
   localparam int STAT_CNT_LSB = 0;
   localparam int STAT_MODE_LSB = 12;
   localparam int STAT_REQ_BIT = 16;
   localparam int STAT_BUSY_BIT = 17;
   localparam int STAT_EXT_BIT = 18;

   localparam logic [BUS_DW-1:0] BUS_ZERO = 32'h0000_0000;
   localparam logic [15:0] DONE_ZERO = 16'h0000;
   localparam logic [15:0] DONE_ONE = 16'h0001;

   // ==========================================================
   // operating modes and forced refresh sequence
   typedef enum logic [1:0] {
      MODE_EXT_REFRESH,
      MODE_AUTO_REFRESH,
      MODE_EXT_ACCESS,
      MODE_AUTO_ACCESS
   } dra_mode_t;

   typedef enum logic [2:0] {
      F_IDLE,
      F_ARM,
      F_LOW,
      F_HOLD,
      F_DONE
   } dra_fstate_t;

   // ==========================================================
   // carriers
   typedef struct packed {
      logic [ADDR_W-1:0] row;
      logic [ADDR_W-1:0] col;
   } dra_addr_in_t;

   typedef struct packed {
      logic [BANKS-1:0] row_n;
      logic column_n;
      logic write_n;
   } dra_strobes_t;

endpackage

/* File: design/dra_refresh_ctrl.sv */
// refresh counter, address latches, mode decode and forced refresh control
//
// Contract
// R1 - access: only decoded bank strobe follows input; with paired control bit set, the pair picked by bank select high follows
// R2 - latches transparent while strobe high, hold on fall
// R3 - system keeps addresses valid or drops strobe
// R4 - nine-bit refresh counter wraps 511 to zero
// R5 - ten address outputs, nine-bit counter
// R6 - write strobe output copies write input always
// R7 - system picks read/write/rmw via write timing
// R8 - reset clears counter and control flops
// R9 - two mode inputs decode into four modes
// R10 - mode 0: counter out, all strobes follow
// R11 - external refresh: increment on row strobe rise
// R12 - system holds refresh-select until strobe rises
// R13 - system lowers refresh-select before row strobe
// R14 - request pin pulled low clears counter
// R15 - system bursts by toggling row strobe
// R16 - mode 1 reuses pins as refresh clocks
// R17 - clock high at mode 1 entry: act mode 0
// R18 - clock falls without refresh: request at once
// R19 - system finishes access then lowers refresh-select
// R20 - forced strobes low second fall, two more
// R21 - request removed when forced strobes go low
// R22 - system resets counter with open-collector driver
// R23 - column strobe output high during refresh
`timescale 1ns/100ps
module dra_refresh_ctrl
   import dra_pkg::*;
(
   input wire logic sys_clk,
   input wire logic reset,
   input wire dra_pkg::dra_addr_in_t addr_in,
   input wire logic bank_select_high,
   input wire logic bank_select_low,
   input wire logic address_latch_strobe,
   input wire logic row_strobe_in,
   input wire logic column_strobe_in,
   input wire logic write_strobe_in,
   input wire logic mode_select_high,
   input wire logic mode_select_low,
   input wire logic row_col_select,
   input wire logic refresh_request_i,
   output logic refresh_request_o,
   output logic refresh_request_oe,
   output logic [dra_pkg::ADDR_W-1:0] addr_out,
   output dra_pkg::dra_strobes_t strobes_out,
   input wire logic [dra_pkg::BUS_AW-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [dra_pkg::BUS_DW-1:0] avs_writedata,
   output logic [dra_pkg::BUS_DW-1:0] avs_readdata,
   output logic avs_waitrequest
);
   import dra_pkg::*;

   // ==========================================================
   // helpers
   function automatic dra_mode_t decode_mode(input logic hi, input logic lo);
      dra_mode_t m;
      case ({hi, lo}) // R9
         2'b00: m = MODE_EXT_REFRESH;
         2'b01: m = MODE_AUTO_REFRESH;
         2'b10: m = MODE_EXT_ACCESS;
         default: m = MODE_AUTO_ACCESS;
      endcase
      return m;
   endfunction

   function automatic logic [BANKS-1:0] bank_enable(input logic hi, input logic lo,
                                                    input logic paired);
      logic [BANKS-1:0] e;
      e = '0;
      if (paired) begin
         e = hi ? 4'hC : 4'h3;
      end else begin
         e[{hi, lo}] = 1'b1;
      end
      return e;
   endfunction

   // ==========================================================
   // state
   dra_mode_t mode;
   dra_mode_t mode_prev_reg;
   dra_fstate_t fstate_reg, fstate_next;
   logic [CNT_W-1:0] cnt_reg, cnt_next;
   dra_addr_in_t latch_reg, latch_next;
   logic bank_hi_reg, bank_hi_next, bank_lo_reg, bank_lo_next;
   logic rs_prev_reg, cs_prev_reg, refresh_period_clock_prev_reg;
   logic ext_like_reg, ext_like_next;
   logic refreshed_reg, refreshed_next;
   logic req_reg, req_next;
   logic [ADDR_W-1:0] addr_next;
   dra_strobes_t strobes_next;
   logic [15:0] done_reg, done_next;
   logic paired_reg, paired_next;
   logic soft_clear;
   logic ext_like, ext_refresh, forced_mode, refresh_mode, auto_mode;
   logic rs_rise, strobe_generator_clock_fall, refresh_period_clock_fall, inc, pin_clear;
   dra_addr_in_t addr_now;
   logic bank_hi_now, bank_lo_now;
   logic [BANKS-1:0] en;

   assign mode = decode_mode(mode_select_high, mode_select_low);

   // ==========================================================
   // core next state
   always_comb begin
      // mode 1 entry with the period clock high latches external behaviour
      ext_like = (mode_prev_reg != MODE_AUTO_REFRESH) ? row_col_select : ext_like_reg; // R17
      ext_like_next = ext_like;
      refresh_mode = (mode == MODE_EXT_REFRESH) || (mode == MODE_AUTO_REFRESH);
      auto_mode = (mode == MODE_AUTO_REFRESH) || (mode == MODE_AUTO_ACCESS);
      ext_refresh = (mode == MODE_EXT_REFRESH) ||
                    ((mode == MODE_AUTO_REFRESH) && ext_like); // R10 R17
      forced_mode = (mode == MODE_AUTO_REFRESH) && !ext_like; // R16
      rs_rise = row_strobe_in && !rs_prev_reg;
      strobe_generator_clock_fall = !column_strobe_in && cs_prev_reg; // R16
      refresh_period_clock_fall = !row_col_select && refresh_period_clock_prev_reg && auto_mode; // R16
      // own request also pulls the pin low, so only an outside low clears
      pin_clear = !refresh_request_i && !req_reg && refresh_mode; // R14
      // forced refresh sequence on generator clock falls
      fstate_next = fstate_reg;
      inc = 1'b0;
      if (!forced_mode) begin
         fstate_next = F_IDLE;
         // refresh-select lifted early still counts the row as done
         inc = (fstate_reg == F_LOW) || (fstate_reg == F_HOLD);
      end else if (strobe_generator_clock_fall) begin
         case (fstate_reg) // R20
            F_IDLE: fstate_next = F_ARM;
            F_ARM: fstate_next = F_LOW;
            F_LOW: fstate_next = F_HOLD;
            F_HOLD: begin
               fstate_next = F_DONE;
               inc = 1'b1;
            end
            F_DONE: fstate_next = F_DONE;
            default: fstate_next = F_IDLE;
         endcase
      end
      if (ext_refresh && rs_rise) begin
         inc = 1'b1; // R11
      end
      // counter: clear beats increment
      cnt_next = cnt_reg;
      if (pin_clear || soft_clear) begin
         cnt_next = CNT_ZERO; // R14
      end else if (inc) begin
         cnt_next = (cnt_reg == CNT_LAST) ? CNT_ZERO : cnt_reg + CNT_ONE; // R4
      end
      done_next = inc ? done_reg + DONE_ONE : done_reg;
      // request: set on a fall with no refresh, set wins over clear
      refreshed_next = inc || (refreshed_reg && !refresh_period_clock_fall);
      req_next = req_reg;
      if ((fstate_next == F_LOW) && (fstate_reg != F_LOW)) begin
         req_next = 1'b0; // R21
      end
      if (refresh_period_clock_fall && !refreshed_reg && !inc) begin
         req_next = 1'b1; // R18
      end
      // transparent latches
      addr_now = address_latch_strobe ? addr_in : latch_reg; // R2
      bank_hi_now = address_latch_strobe ? bank_select_high : bank_hi_reg;
      bank_lo_now = address_latch_strobe ? bank_select_low : bank_lo_reg;
      latch_next = addr_now;
      bank_hi_next = bank_hi_now;
      bank_lo_next = bank_lo_now;
      en = bank_enable(bank_hi_now, bank_lo_now, paired_reg);
      // output mux
      strobes_next.write_n = write_strobe_in; // R6
      if (refresh_mode) begin
         addr_next = {1'b0, cnt_next}; // R5 R10
         strobes_next.column_n = 1'b1; // R23
         if (forced_mode) begin
            strobes_next.row_n = ((fstate_next == F_LOW) || (fstate_next == F_HOLD)) ?
                                 '0 : '1; // R20
         end else begin
            strobes_next.row_n = {BANKS{row_strobe_in}}; // R10
         end
      end else begin
         addr_next = row_col_select ? addr_now.row : addr_now.col; // R5
         strobes_next.column_n = row_col_select ? 1'b1 : column_strobe_in;
         strobes_next.row_n = ~en | {BANKS{row_strobe_in}}; // R1
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin // R8
         mode_prev_reg <= MODE_EXT_REFRESH;
         fstate_reg <= F_IDLE;
         cnt_reg <= CNT_ZERO;
         latch_reg <= '0;
         bank_hi_reg <= 1'b0;
         bank_lo_reg <= 1'b0;
         rs_prev_reg <= 1'b1;
         cs_prev_reg <= 1'b1;
         refresh_period_clock_prev_reg <= 1'b0;
         ext_like_reg <= 1'b0;
         refreshed_reg <= 1'b0;
         req_reg <= 1'b0;
         done_reg <= DONE_ZERO;
         addr_out <= '0;
         strobes_out <= '1;
         refresh_request_o <= 1'b0;
         refresh_request_oe <= 1'b0;
      end else begin
         mode_prev_reg <= mode;
         fstate_reg <= fstate_next;
         cnt_reg <= cnt_next;
         latch_reg <= latch_next;
         bank_hi_reg <= bank_hi_next;
         bank_lo_reg <= bank_lo_next;
         rs_prev_reg <= row_strobe_in;
         cs_prev_reg <= column_strobe_in;
         refresh_period_clock_prev_reg <= row_col_select;
         ext_like_reg <= ext_like_next;
         refreshed_reg <= refreshed_next;
         req_reg <= req_next;
         done_reg <= done_next;
         addr_out <= addr_next;
         strobes_out <= strobes_next;
         refresh_request_o <= 1'b0;
         refresh_request_oe <= req_next;
      end
   end

   // ==========================================================
   // avalon slave: answers one cycle after the request is seen
   logic wait_next;
   logic [BUS_DW-1:0] rdata_next;
   logic [BUS_DW-1:0] status_word;

   always_comb begin
      status_word = BUS_ZERO;
      status_word[STAT_CNT_LSB +: CNT_W] = cnt_reg;
      status_word[STAT_MODE_LSB +: 2] = mode;
      status_word[STAT_REQ_BIT] = req_reg;
      status_word[STAT_BUSY_BIT] = (fstate_reg == F_LOW) || (fstate_reg == F_HOLD);
      status_word[STAT_EXT_BIT] = ext_like_reg;
      wait_next = !((avs_read || avs_write) && avs_waitrequest);
      rdata_next = avs_readdata;
      if (avs_read && avs_waitrequest) begin
         case (avs_address)
            ADDR_CTRL: rdata_next = {{(BUS_DW-1){1'b0}}, paired_reg};
            ADDR_STATUS: rdata_next = status_word;
            ADDR_DONE: rdata_next = {DONE_ZERO, done_reg};
            default: rdata_next = BUS_ZERO;
         endcase
      end
      paired_next = paired_reg;
      soft_clear = 1'b0;
      // write lands on the edge where the master sees waitrequest low
      if (avs_write && !avs_waitrequest && (avs_address == ADDR_CTRL)) begin
         paired_next = avs_writedata[CTRL_PAIRED_BIT];
         soft_clear = avs_writedata[CTRL_CLEAR_BIT];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= BUS_ZERO;
         paired_reg <= CTRL_PAIRED_RST;
      end else begin
         avs_waitrequest <= wait_next;
         avs_readdata <= rdata_next;
         paired_reg <= paired_next;
      end
   end

   // ==========================================================
   // checks
   a_write_copy: assert property (@(posedge sys_clk) disable iff (reset) // R6
      1'b1 |=> strobes_out.write_n == $past(write_strobe_in))
      else $error("write strobe output not copying input");
   a_cnt_wrap: assert property (@(posedge sys_clk) disable iff (reset) // R4
      (cnt_reg == CNT_LAST) && inc && !pin_clear && !soft_clear |=> cnt_reg == CNT_ZERO)
      else $error("refresh counter did not wrap");
   a_ext_inc: assert property (@(posedge sys_clk) disable iff (reset) // R11
      ext_refresh && rs_rise && !pin_clear && !soft_clear
      |=> cnt_reg == CNT_W'($past(cnt_reg) + CNT_ONE))
      else $error("counter missed row strobe rise");
   a_pin_clear: assert property (@(posedge sys_clk) disable iff (reset) // R14
      !refresh_request_i && !refresh_request_oe && refresh_mode |=> cnt_reg == CNT_ZERO)
      else $error("outside low on request pin did not clear counter");
   a_cas_high: assert property (@(posedge sys_clk) disable iff (reset) // R23
      refresh_mode |=> strobes_out.column_n)
      else $error("column strobe low during refresh");
   a_all_follow: assert property (@(posedge sys_clk) disable iff (reset) // R10
      mode == MODE_EXT_REFRESH |=> strobes_out.row_n == {BANKS{$past(row_strobe_in)}})
      else $error("row strobes not all following in mode 0");
   a_req_raise: assert property (@(posedge sys_clk) disable iff (reset) // R18
      refresh_period_clock_fall && !refreshed_reg && !inc |=> refresh_request_oe)
      else $error("no refresh request after missed period");
   a_forced_seq: assert property (@(posedge sys_clk) disable iff (reset) // R20 R21
      forced_mode && (fstate_reg == F_ARM) && strobe_generator_clock_fall
      |=> (strobes_out.row_n == '0) && !refresh_request_oe)
      else $error("forced strobes not low or request held");
   a_addr_pass: assert property (@(posedge sys_clk) disable iff (reset) // R2
      address_latch_strobe && (mode == MODE_EXT_ACCESS) && row_col_select
      |=> addr_out == $past(addr_in.row))
      else $error("row address not passed through");

endmodule // dra_refresh_ctrl

/* File: tb/dra_pin_partner.sv */
// far side model: pull-up on the request pin and an outside open-collector gate
`timescale 1ns/100ps
module dra_pin_partner (
   input wire logic dev_drive,
   input wire logic dev_enable,
   input wire logic outside_pull,
   output logic pin_level
);
   // ==========================================================
   // pin resolution
   // wired-and with pull-up; the outside gate only sinks, never drives high
   assign pin_level = !((dev_enable && !dev_drive) || outside_pull);
endmodule // dra_pin_partner

/* File: tb/tb.sv */
// self-checking bench of the refresh and address controller
`timescale 1ns/100ps
module tb;
   import dra_pkg::*;
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   dra_addr_in_t addr_in = '0;
   logic bank_select_high = 1'b0;
   logic bank_select_low = 1'b0;
   logic address_latch_strobe = 1'b1;
   logic row_strobe_in = 1'b1;
   logic column_strobe_in = 1'b1;
   logic write_strobe_in = 1'b1;
   logic mode_select_high = 1'b1;
   logic mode_select_low = 1'b1;
   logic row_col_select = 1'b0;
   logic outside_pull = 1'b0;
   logic pin_level;
   logic request_drive;
   logic request_enable;
   logic [ADDR_W-1:0] addr_out;
   dra_strobes_t strobes_out;
   logic [BUS_AW-1:0] avs_address = '0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [BUS_DW-1:0] avs_writedata = '0;
   logic [BUS_DW-1:0] avs_readdata;
   logic avs_waitrequest;
   logic [BUS_DW-1:0] rd;
   logic [CNT_W-1:0] exp_cnt = '0;
   int miscompares = 0;
   int compares = 0;

   always #25 sys_clk = ~sys_clk;

   dra_refresh_ctrl u_dut (.sys_clk(sys_clk), .reset(reset), .addr_in(addr_in),
      .bank_select_high(bank_select_high), .bank_select_low(bank_select_low),
      .address_latch_strobe(address_latch_strobe), .row_strobe_in(row_strobe_in),
      .column_strobe_in(column_strobe_in), .write_strobe_in(write_strobe_in),
      .mode_select_high(mode_select_high), .mode_select_low(mode_select_low),
      .row_col_select(row_col_select), .refresh_request_i(pin_level),
      .refresh_request_o(request_drive), .refresh_request_oe(request_enable),
      .addr_out(addr_out), .strobes_out(strobes_out), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

   dra_pin_partner u_pin (.dev_drive(request_drive), .dev_enable(request_enable),
      .outside_pull(outside_pull), .pin_level(pin_level));

   // ==========================================================
   // shared tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
         miscompares++;
      end
   endtask

   // one edge to sample the drive, outputs read half a cycle later
   task automatic see;
      @(posedge sys_clk);
      @(negedge sys_clk);
   endtask

   // no own limit: only the watchdog ends a wait that never answers
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
      @(posedge sys_clk);
      avs_address <= a;
      avs_writedata <= wd;
      avs_read <= !wr;
      avs_write <= wr;
      do begin
         @(posedge sys_clk);
      end while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask

   task automatic mode(input logic [1:0] m);
      @(posedge sys_clk);
      {mode_select_high, mode_select_low} <= m;
      see;
   endtask

   task automatic ref0;
      @(posedge sys_clk);
      row_strobe_in <= 1'b0;
      see;
      chk(32'(strobes_out.row_n), 32'h0);
      chk(32'(strobes_out.column_n), 32'h1);
      chk(32'(addr_out), 32'(exp_cnt));
      @(posedge sys_clk);
      row_strobe_in <= 1'b1;
      see;
      exp_cnt++;
      see;
      chk(32'(addr_out), 32'(exp_cnt));
   endtask

   task automatic gfall(input logic [3:0] r);
      @(posedge sys_clk);
      column_strobe_in <= 1'b1;
      @(posedge sys_clk);
      column_strobe_in <= 1'b0;
      see;
      chk(32'(strobes_out.row_n), 32'(r));
   endtask

   // ==========================================================
   // scenarios
   task automatic t_reset;
      chk(32'(addr_out), 32'h0);
      chk(32'(strobes_out), 32'h3F);
      bus(1'b0, ADDR_STATUS, BUS_ZERO);
      chk(32'(rd[8:0]), 32'h0);
      bus(1'b0, 4'hC, BUS_ZERO);
      chk(rd, 32'h0);
      for (int m = 0; m < 4; m++) begin
         mode(2'(m));
         bus(1'b0, ADDR_STATUS, BUS_ZERO);
         chk(32'(rd[13:12]), 32'(m));
      end
   endtask

   task automatic t_ext;
      mode(2'b00);
      ref0;
      ref0;
      @(posedge sys_clk);
      outside_pull <= 1'b1;
      see;
      @(posedge sys_clk);
      outside_pull <= 1'b0;
      exp_cnt = '0;
      see;
      chk(32'(addr_out), 32'h0);
      // burst over all rows, wrap checked on the last one
      repeat (512) ref0;
   endtask

   task automatic t_forced;
      @(posedge sys_clk);
      reset <= 1'b1;
      row_col_select <= 1'b0;
      @(posedge sys_clk);
      reset <= 1'b0;
      exp_cnt = '0;
      mode(2'b11);
      @(posedge sys_clk);
      row_col_select <= 1'b1;
      repeat (4) @(posedge sys_clk);
      row_col_select <= 1'b0;
      see;
      chk(32'(request_enable), 32'h1);
      chk(32'(pin_level), 32'h0);
      bus(1'b0, ADDR_STATUS, BUS_ZERO);
      chk(32'(rd[STAT_REQ_BIT]), 32'h1);
      mode(2'b01);
      chk(32'(addr_out), 32'(exp_cnt));
      gfall(4'hF);
      gfall(4'h0);
      chk(32'(request_enable), 32'h0);
      chk(32'(strobes_out.column_n), 32'h1);
      gfall(4'h0);
      gfall(4'hF);
      see;
      chk(32'(addr_out), 32'h1);
      mode(2'b11);
      bus(1'b0, ADDR_DONE, BUS_ZERO);
      chk(32'(rd[15:0]), 32'h1);
      exp_cnt = 9'h001;
      @(posedge sys_clk);
      row_col_select <= 1'b1;
      mode(2'b01);
      bus(1'b0, ADDR_STATUS, BUS_ZERO);
      chk(32'(rd[STAT_EXT_BIT]), 32'h1);
      ref0;
      mode(2'b11);
   endtask

   task automatic t_access;
      mode(2'b10);
      @(posedge sys_clk);
      addr_in <= {10'h2A5, 10'h15A};
      row_col_select <= 1'b1;
      bank_select_high <= 1'b1;
      write_strobe_in <= 1'b0;
      row_strobe_in <= 1'b0;
      see;
      chk(32'(addr_out), 32'h2A5);
      chk(32'(strobes_out.row_n), 32'hB);
      chk(32'(strobes_out.write_n), 32'h0);
      @(posedge sys_clk);
      address_latch_strobe <= 1'b0;
      see;
      @(posedge sys_clk);
      addr_in <= 20'hFFFFF;
      bank_select_high <= 1'b0;
      see;
      chk(32'(addr_out), 32'h2A5);
      chk(32'(strobes_out.row_n), 32'hB);
      @(posedge sys_clk);
      row_col_select <= 1'b0;
      see;
      chk(32'(addr_out), 32'h15A);
      bus(1'b1, ADDR_CTRL, 32'h0000_0001);
      see;
      chk(32'(strobes_out.row_n), 32'h3);
      @(posedge sys_clk);
      row_strobe_in <= 1'b1;
      write_strobe_in <= 1'b1;
      address_latch_strobe <= 1'b1;
      see;
      chk(32'(strobes_out.write_n), 32'h1);
      bus(1'b1, ADDR_CTRL, BUS_ZERO);
   endtask

   // ==========================================================
   // run control
   task automatic report_and_stop;
      $display("compares=%0d miscompares=%0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   initial begin
      repeat (10) @(posedge sys_clk);
      reset <= 1'b0;
      @(negedge sys_clk);
      t_reset;
      t_ext;
      t_access;
      t_forced;
      report_and_stop;
   end

   // burst dominates: five cycles per row
   initial begin
      repeat (20000) @(posedge sys_clk);
      $display("BAD t=%0t timeout got=%h exp=%h", $time, 1'b0, 1'b1);
      miscompares++;
      report_and_stop;
   end
endmodule // tb
